/* design/event_detect_pkg.sv */
/*
 * constants for the freefall / motion event detector: register offsets,
 * field positions, reset values and data widths.
 * assumes one sample clock domain and an 8-bit register port.
 */
package event_detect_pkg;

    // data widths
    localparam int unsigned REG_AW   = 8;  // register address width
    localparam int unsigned REG_DW   = 8;  // register data width
    localparam int unsigned ACCEL_W  = 8;  // signed axis sample, +-8 g scale
    localparam int unsigned THS_W    = 7;  // threshold field width
    localparam int unsigned CNT_W    = 8;  // debounce counter width

    // register offsets
    localparam logic [REG_AW-1:0] OFS_CONFIG    = 8'h15; // event_detect_config
    localparam logic [REG_AW-1:0] OFS_SOURCE    = 8'h16; // event_detect_source
    localparam logic [REG_AW-1:0] OFS_THRESHOLD = 8'h17; // event_threshold
    localparam logic [REG_AW-1:0] OFS_COUNT     = 8'h18; // debounce_count
    localparam logic [REG_AW-1:0] OFS_IRQ_CTRL  = 8'h19; // irq enable and routing

    // event_detect_config fields
    localparam int unsigned CFG_LATCH_BIT   = 7;  // latch_enable
    localparam int unsigned CFG_COMBINE_BIT = 6;  // combine_select
    localparam int unsigned CFG_ZEN_BIT     = 5;  // z_axis_enable
    localparam int unsigned CFG_YEN_BIT     = 4;  // y_axis_enable
    localparam int unsigned CFG_XEN_BIT     = 3;  // x_axis_enable

    // event_detect_source fields
    localparam int unsigned SRC_EA_BIT      = 7;  // event_active
    localparam int unsigned SRC_Z_LSB       = 4;  // z event/polarity pair
    localparam int unsigned SRC_Y_LSB       = 2;  // y event/polarity pair
    localparam int unsigned SRC_X_LSB       = 0;  // x event/polarity pair

    // event_threshold fields
    localparam int unsigned THS_MODE_BIT    = 7;  // debounce_mode

    // detector irq control fields
    localparam int unsigned IRQ_EN_BIT      = 0;  // detector_irq_enable
    localparam int unsigned IRQ_ROUTE_BIT   = 1;  // detector_irq_route

    // reset values and counter constants
    localparam logic [REG_DW-1:0] CONFIG_RST    = 8'h00;
    localparam logic [REG_DW-1:0] THRESHOLD_RST = 8'h00;
    localparam logic [REG_DW-1:0] COUNT_RST     = 8'h00;
    localparam logic [REG_DW-1:0] IRQ_CTRL_RST  = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ZERO      = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE       = 8'h01;
    localparam logic [5:0]        FLAGS_RST     = 6'h00;

endpackage : event_detect_pkg

/* design/axis_compare.sv */
/*
 * one axis of the detector: magnitude of a signed sample against the
 * unsigned threshold, plus the sign of the sample.
 * assumes the sample is already in the fixed +-8 g detection scale.
 */
module axis_compare
    import event_detect_pkg::*;
(
    input  wire logic signed [event_detect_pkg::ACCEL_W-1:0] sample,
    input  wire logic        [event_detect_pkg::THS_W-1:0]   threshold,
    output logic                                             above,
    output logic                                             negative
);

    // absolute value; -128 maps to 128, which still fits unsigned
    function automatic logic [ACCEL_W-1:0] magnitude(input logic signed [ACCEL_W-1:0] s);
        logic [ACCEL_W-1:0] r;
        r = s[ACCEL_W-1] ? ACCEL_W'(-s) : ACCEL_W'(s);
        return r;
    endfunction

    // strictly greater than is motion; at or below is low-g  [RQ8] [RQ9] [RQ13] [RQ15]
    assign above    = magnitude(sample) > {1'b0, threshold};
    // sign bit set means a negative-g event  [RQ12]
    assign negative = sample[ACCEL_W-1];

endmodule // axis_compare

/* design/freefall_motion_detector.sv */
/*
 * freefall / motion event detector with debounce and source latching,
 * reached over a plain address / strobe register port.
 * assumes sample_valid is a one-cycle strobe per output sample and that
 * axis samples come from logic on ref_clk in the +-8 g detection scale.
 */
// How it works
// RQ1 - latch mode freezes flags until source read
// RQ2 - without latch, flags follow every sample
// RQ3 - latched source read clears every source bit
// RQ4 - combine select: 0 AND freefall, 1 OR
// RQ5 - axis enable bits include axes, reset excluded
// RQ6 - event active follows debounced combined condition
// RQ7 - event active gated by irq enable, routing
// RQ8 - motion when magnitude strictly above threshold
// RQ9 - freefall when enabled magnitudes at/below threshold
// RQ10 - source layout: active bit7, pairs z/y/x
// RQ11 - disabled axis flags always read zero
// RQ12 - polarity zero positive, one negative g
// RQ13 - unsigned 7-bit threshold, reset zero
// RQ14 - threshold step 0.063 g per count
// RQ15 - compare on fixed +-8 g data
// RQ16 - mode 0: count up, down otherwise
// RQ17 - mode 1: clear counter when condition false
// RQ18 - mode 0: decrement by one down to zero
// RQ19 - flag at count value, never beyond it
// RQ20 - count register 8-bit read/write, reset zero
// RQ21 - unlatched source read changes nothing
// RQ22 - counter steps only on sample strobe
module freefall_motion_detector
    import event_detect_pkg::*;
(
    input  wire logic                                       ref_clk,      // sample clock
    input  wire logic                                       rst_n,        // sync reset, low
    input  wire logic                                       sample_valid, // new sample strobe
    input  wire logic signed [event_detect_pkg::ACCEL_W-1:0] accel_x,     // x sample
    input  wire logic signed [event_detect_pkg::ACCEL_W-1:0] accel_y,     // y sample
    input  wire logic signed [event_detect_pkg::ACCEL_W-1:0] accel_z,     // z sample
    input  wire logic        [event_detect_pkg::REG_AW-1:0]  reg_addr,    // register address
    input  wire logic        [event_detect_pkg::REG_DW-1:0]  reg_wdata,   // write data
    input  wire logic                                       reg_wr,       // write strobe
    input  wire logic                                       reg_rd,       // read strobe
    output logic             [event_detect_pkg::REG_DW-1:0]  reg_rdata,   // read data
    output logic                                            irq_line1,    // irq, route 0
    output logic                                            irq_line2     // irq, route 1
);

    import event_detect_pkg::*;

    // software registers
    logic [REG_DW-1:0] config_q;     // event_detect_config
    logic [REG_DW-1:0] threshold_q;  // event_threshold
    logic [REG_DW-1:0] count_q;      // debounce_count
    logic [REG_DW-1:0] irq_ctrl_q;   // enable and routing
    logic [REG_DW-1:0] rdata_q;      // read data stage
    logic              irq1_q;       // irq line 1 flop
    logic              irq2_q;       // irq line 2 flop

    // detector state
    logic [CNT_W-1:0]  cnt_q;        // debounce counter
    logic [CNT_W-1:0]  cnt_d;        // its next value
    logic              ea_q;         // event active
    logic [5:0]        flags_q;      // z,y,x event/polarity pairs

    // decoded controls
    logic              latch_enable;
    logic              combine_select;
    logic [2:0]        axis_en;      // {z,y,x}
    logic              debounce_mode;
    logic [THS_W-1:0]  threshold_value;

    // per-axis compare results {z,y,x}
    logic [2:0]        above;
    logic [2:0]        negative;
    logic [5:0]        live_flags;   // real-time pairs
    logic              cond;         // combined condition
    logic              src_read;     // read strobe on source
    logic              rd_clr;       // latched-mode read clear
    logic              ea_set;       // debounce complete this sample
    logic              ea_drop;      // unlatched release this sample

    // expand {z,y,x} enables into the six source bit mask
    function automatic logic [5:0] pair_mask(input logic [2:0] en);
        return {en[2], en[2], en[1], en[1], en[0], en[0]};
    endfunction

    // source register image, disabled axes forced to zero
    function automatic logic [REG_DW-1:0] source_image(input logic       ea,
                                                       input logic [5:0] fl,
                                                       input logic [2:0] en);
        return {ea, 1'b0, fl & pair_mask(en)};  // [RQ10] [RQ11]
    endfunction

    assign latch_enable    = config_q[CFG_LATCH_BIT];
    assign combine_select  = config_q[CFG_COMBINE_BIT];
    assign axis_en         = {config_q[CFG_ZEN_BIT], config_q[CFG_YEN_BIT],
                              config_q[CFG_XEN_BIT]};
    assign debounce_mode   = threshold_q[THS_MODE_BIT];
    assign threshold_value = threshold_q[THS_W-1:0];

    // one comparator per axis
    axis_compare u_cmp_x (
        .sample    (accel_x),
        .threshold (threshold_value),
        .above     (above[0]),
        .negative  (negative[0])
    );
    axis_compare u_cmp_y (
        .sample    (accel_y),
        .threshold (threshold_value),
        .above     (above[1]),
        .negative  (negative[1])
    );
    axis_compare u_cmp_z (
        .sample    (accel_z),
        .threshold (threshold_value),
        .above     (above[2]),
        .negative  (negative[2])
    );

    // live flags: high-g per enabled axis, with its sign  [RQ5] [RQ12]
    assign live_flags = {above[2], above[2] & negative[2],
                         above[1], above[1] & negative[1],
                         above[0], above[0] & negative[0]} & pair_mask(axis_en);

    // OR of enabled highs for motion, AND of enabled lows for freefall
    always_comb
    begin
        if (combine_select)
        begin
            cond = |(above & axis_en);                     // [RQ4] [RQ8]
        end
        else
        begin
            cond = (&(~above | ~axis_en)) && (|axis_en);   // [RQ4] [RQ9]
        end
    end

    assign src_read = reg_rd && (reg_addr == OFS_SOURCE);
    assign rd_clr   = src_read && latch_enable;            // [RQ3] [RQ21]

    // next counter value; a sample after a clearing read starts from zero
    always_comb
    begin
        cnt_d = cnt_q;
        if (rd_clr)
        begin
            cnt_d = CNT_ZERO;                              // [RQ3]
        end
        if (sample_valid)                                  // [RQ22]
        begin
            if (cond)
            begin
                // saturate at the programmed count  [RQ16] [RQ19]
                cnt_d = (cnt_d < count_q) ? cnt_d + CNT_ONE : count_q;
            end
            else if (debounce_mode)
            begin
                cnt_d = CNT_ZERO;                          // [RQ17]
            end
            else if (cnt_d != CNT_ZERO)
            begin
                cnt_d = cnt_d - CNT_ONE;                   // [RQ16] [RQ18]
            end
        end
    end

    assign ea_set  = sample_valid && cond && (cnt_d == count_q);              // [RQ6] [RQ19]
    assign ea_drop = sample_valid && !cond && (debounce_mode || cnt_d == CNT_ZERO);

    // debounce counter
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= CNT_ZERO;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // event active: set wins over any clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ea_q <= 1'b0;
        end
        else if (ea_set)
        begin
            ea_q <= 1'b1;                                  // [RQ6]
        end
        else if (latch_enable ? rd_clr : ea_drop)
        begin
            ea_q <= 1'b0;                                  // [RQ3]
        end
    end

    // source flags: live unless frozen by a latched event
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            flags_q <= FLAGS_RST;
        end
        else if (sample_valid && !(latch_enable && ea_q))
        begin
            flags_q <= live_flags;                         // [RQ1] [RQ2]
        end
        else if (rd_clr)
        begin
            flags_q <= FLAGS_RST;                          // [RQ3]
        end
    end

    // software writes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            config_q    <= CONFIG_RST;
            threshold_q <= THRESHOLD_RST;                  // [RQ13] [RQ14]
            count_q     <= COUNT_RST;                      // [RQ20]
            irq_ctrl_q  <= IRQ_CTRL_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFS_CONFIG:    config_q    <= {reg_wdata[7:3], 3'b000};
                OFS_THRESHOLD: threshold_q <= reg_wdata;
                OFS_COUNT:     count_q     <= reg_wdata;   // [RQ20]
                OFS_IRQ_CTRL:  irq_ctrl_q  <= {6'h00, reg_wdata[1:0]};
                default:       ;                           // unmapped: ignored
            endcase
        end
    end

    // read data: valid only in the cycle after the strobe, else zero
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                OFS_CONFIG:    rdata_q <= config_q;
                OFS_SOURCE:    rdata_q <= source_image(ea_q, flags_q, axis_en); // [RQ10]
                OFS_THRESHOLD: rdata_q <= threshold_q;
                OFS_COUNT:     rdata_q <= count_q;
                OFS_IRQ_CTRL:  rdata_q <= irq_ctrl_q;
                default:       rdata_q <= '0;              // unmapped reads zero
            endcase
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    // interrupt lines: event active gated by enable and routing
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq1_q <= 1'b0;
            irq2_q <= 1'b0;
        end
        else
        begin
            irq1_q <= ea_q && irq_ctrl_q[IRQ_EN_BIT] && !irq_ctrl_q[IRQ_ROUTE_BIT]; // [RQ7]
            irq2_q <= ea_q && irq_ctrl_q[IRQ_EN_BIT] && irq_ctrl_q[IRQ_ROUTE_BIT];  // [RQ7]
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_line1 = irq1_q;
    assign irq_line2 = irq2_q;

    // checks, all on ref_clk and disabled in reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    freeze_flags_a: assert property ( // [RQ1]
        latch_enable && ea_q && !rd_clr |=> $stable(flags_q))
        else $error("latched flags changed before source read");

    live_flags_a: assert property ( // [RQ2]
        !latch_enable && sample_valid |=> flags_q == $past(live_flags))
        else $error("unlatched flags did not follow the sample");

    src_clear_a: assert property ( // [RQ3]
        rd_clr && !sample_valid |=> !ea_q && flags_q == FLAGS_RST && cnt_q == CNT_ZERO)
        else $error("latched source read did not clear");

    unlatched_read_a: assert property ( // [RQ21]
        src_read && !latch_enable && !sample_valid |=> $stable(cnt_q) && $stable(flags_q))
        else $error("unlatched source read disturbed state");

    cnt_inc_a: assert property ( // [RQ16]
        sample_valid && cond && cnt_q < count_q && !rd_clr && !reg_wr
        |=> cnt_q == $past(cnt_q) + CNT_ONE)
        else $error("counter did not increment");

    cnt_clear_a: assert property ( // [RQ17]
        sample_valid && !cond && debounce_mode |=> cnt_q == CNT_ZERO)
        else $error("counter not cleared in clear mode");

    cnt_dec_a: assert property ( // [RQ18]
        sample_valid && !cond && !debounce_mode && cnt_q != CNT_ZERO && !rd_clr
        |=> cnt_q == $past(cnt_q) - CNT_ONE)
        else $error("counter did not decrement by one");

    cnt_bound_a: assert property ( // [RQ19]
        sample_valid && cond && !reg_wr |=> cnt_q <= count_q)
        else $error("counter passed the count value");

    cnt_hold_a: assert property ( // [RQ22]
        !sample_valid && !rd_clr |=> $stable(cnt_q))
        else $error("counter moved without a sample");

    ea_set_a: assert property ( // [RQ6]
        sample_valid && cond && cnt_d == count_q |=> ea_q ##1 irq_line1 || irq_line2
            || !$past(irq_ctrl_q[IRQ_EN_BIT]))
        else $error("event active or irq missing after debounce");

    irq_gate_a: assert property ( // [RQ7]
        irq_line1 || irq_line2 |-> $past(ea_q) && $past(irq_ctrl_q[IRQ_EN_BIT]))
        else $error("irq without enabled event");

    src_read_a: assert property ( // [RQ11]
        src_read |=> reg_rdata == {$past(ea_q), 1'b0, $past(flags_q) & pair_mask($past(axis_en))})
        else $error("source read data wrong");

    latched_event_c: cover property (latch_enable && ea_set ##[1:20] rd_clr);
    motion_event_c:  cover property (combine_select && !latch_enable && ea_set);
    freefall_drop_c: cover property (!combine_select && ea_q && ea_drop);
    // clear mode dropping a part-filled counter
    clear_mode_c:    cover property (debounce_mode && sample_valid && !cond && cnt_q != CNT_ZERO);
    // true sample arriving with the counter already at the count value
    cnt_saturate_c:  cover property (sample_valid && cond && cnt_q == count_q && cnt_q != CNT_ZERO);

endmodule // freefall_motion_detector

/* sim/accel_source.sv */
/*
 * sample source on the far side of the detector: hands one x/y/z sample
 * at a time with a one-cycle sample strobe.
 * assumes the bench calls send() and that ref_clk runs free.
 */
module accel_source
    import event_detect_pkg::*;
(
    input  wire logic                                  ref_clk,      // sample clock
    output logic                                       sample_valid, // one-cycle strobe
    output logic signed [event_detect_pkg::ACCEL_W-1:0] ax,          // x sample
    output logic signed [event_detect_pkg::ACCEL_W-1:0] ay,          // y sample
    output logic signed [event_detect_pkg::ACCEL_W-1:0] az           // z sample
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle at time zero with no sample offered
    initial
    begin
        sample_valid = 1'b0;
        ax           = 8'h00;
        ay           = 8'h00;
        az           = 8'h00;
    end

    // one strobe per sample; stale data is inverted so nothing relies on it
    task automatic send(input logic signed [ACCEL_W-1:0] x,
                        input logic signed [ACCEL_W-1:0] y,
                        input logic signed [ACCEL_W-1:0] z);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        ax           <= x;
        ay           <= y;
        az           <= z;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        ax           <= ~x;
        ay           <= ~y;
        az           <= ~z;
    endtask
endmodule // accel_source

/* sim/tb_top.sv */
/*
 * self-checking bench for the freefall / motion detector: register port
 * tasks, one task per scenario, verdict in stop_test.
 * assumes accel_source feeds samples and a 100 MHz ref_clk.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import event_detect_pkg::*;

    logic                       ref_clk;      // sample clock
    logic                       rst_n;        // sync reset, low
    logic                       sample_valid; // sample strobe from source
    logic signed [ACCEL_W-1:0]  ax;           // x sample
    logic signed [ACCEL_W-1:0]  ay;           // y sample
    logic signed [ACCEL_W-1:0]  az;           // z sample
    logic        [REG_AW-1:0]   reg_addr;     // register address
    logic        [REG_DW-1:0]   reg_wdata;    // write data
    logic                       reg_wr;       // write strobe
    logic                       reg_rd;       // read strobe
    logic        [REG_DW-1:0]   reg_rdata;    // read data
    logic                       irq_line1;    // irq, route 0
    logic                       irq_line2;    // irq, route 1
    int                         n_errors;     // mismatches
    int                         comparisons;  // compares made
    int                         cycles;       // timeout counter

    freefall_motion_detector u_freefall_motion_detector (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .sample_valid (sample_valid),
        .accel_x      (ax),
        .accel_y      (ay),
        .accel_z      (az),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .irq_line1    (irq_line1),
        .irq_line2    (irq_line2)
    );

    accel_source u_src (
        .ref_clk      (ref_clk),
        .sample_valid (sample_valid),
        .ax           (ax),
        .ay           (ay),
        .az           (az)
    );

    // free-running 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard: far above the few hundred cycles the scenarios need
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end

    // counts and verdict, then end of run
    task automatic stop_test();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // byte compare
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // one-cycle read strobe; data looked at in the cycle after the take edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // synchronous reset for 6 cycles
    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    // reset values, field widths, read-only source, unmapped address
    task automatic t_regs();
        do_reset();
        rd_chk(OFS_CONFIG, 8'h00);
        rd_chk(OFS_THRESHOLD, 8'h00);
        rd_chk(OFS_COUNT, 8'h00);
        rd_chk(OFS_SOURCE, 8'h00);
        wr(OFS_CONFIG, 8'hFF);
        wr(OFS_THRESHOLD, 8'hFF);
        wr(OFS_COUNT, 8'hA5);
        wr(OFS_SOURCE, 8'hFF);
        rd_chk(OFS_CONFIG, 8'hF8);
        rd_chk(OFS_THRESHOLD, 8'hFF);
        rd_chk(OFS_COUNT, 8'hA5);
        rd_chk(OFS_SOURCE, 8'h00);
        rd_chk(OFS_IRQ_CTRL, 8'h00);
        wr(OFS_IRQ_CTRL, 8'hFF);
        rd_chk(OFS_IRQ_CTRL, 8'h03);
        rd_chk(8'h20, 8'h00);
    endtask

    // unlatched motion: strict threshold, polarity, live flags, harmless read
    task automatic t_motion();
        do_reset();
        wr(OFS_CONFIG, 8'h48);
        wr(OFS_THRESHOLD, 8'h0A);
        wr(OFS_COUNT, 8'h01);
        u_src.send(8'sd11, 8'sd50, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h82);
        rd_chk(OFS_SOURCE, 8'h82);
        u_src.send(-8'sd11, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h83);
        u_src.send(8'sd10, 8'sd50, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h00);
    endtask

    // debounce with decrement, then with clear
    task automatic t_debounce();
        do_reset();
        wr(OFS_CONFIG, 8'h48);
        wr(OFS_THRESHOLD, 8'h0A);
        wr(OFS_COUNT, 8'h03);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h02);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h82);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h80);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h00);
        wr(OFS_THRESHOLD, 8'h8A);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h02);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h82);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h00);
    endtask

    // freefall: all enabled axes at or below threshold
    task automatic t_freefall();
        do_reset();
        wr(OFS_CONFIG, 8'h38);
        wr(OFS_THRESHOLD, 8'h0A);
        wr(OFS_COUNT, 8'h01);
        u_src.send(8'sd10, -8'sd10, 8'sd3);
        rd_chk(OFS_SOURCE, 8'h80);
        u_src.send(8'sd11, 8'sd0, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h02);
    endtask

    // latched motion: frozen flags, irq routing, read clears all
    task automatic t_latch();
        do_reset();
        wr(OFS_CONFIG, 8'hC8);
        wr(OFS_THRESHOLD, 8'h0A);
        wr(OFS_COUNT, 8'h01);
        u_src.send(-8'sd20, 8'sd30, 8'sd0);
        u_src.send(8'sd5, 8'sd0, 8'sd0);
        #1;
        check({6'h00, irq_line2, irq_line1}, 8'h00);
        wr(OFS_IRQ_CTRL, 8'h01);
        repeat (3) @(posedge ref_clk);
        #1;
        check({6'h00, irq_line2, irq_line1}, 8'h01);
        wr(OFS_IRQ_CTRL, 8'h03);
        repeat (3) @(posedge ref_clk);
        #1;
        check({6'h00, irq_line2, irq_line1}, 8'h02);
        rd_chk(OFS_SOURCE, 8'h83);
        rd_chk(OFS_SOURCE, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        check({6'h00, irq_line2, irq_line1}, 8'h00);
        u_src.send(8'sd5, -8'sd40, 8'sd0);
        rd_chk(OFS_SOURCE, 8'h00);
    endtask

    // main sequence
    initial
    begin
        rst_n       = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        n_errors    = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_motion();
        t_debounce();
        t_freefall();
        t_latch();
        stop_test();
    end
endmodule // tb_top
